/* hw/alarm_cfg_pkg.sv */
// constants, types and state layout for the alarm output and analog configuration block
// assumes a 32-bit apb slave on pclk and four configurable i/o points
package alarm_cfg_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_ALARM = 8'h00;
  localparam logic [7:0] OFS_GAIN = 8'h04;
  localparam logic [7:0] OFS_SCALE = 8'h08;
  localparam logic [7:0] OFS_DIR = 8'h0c;
  localparam logic [7:0] OFS_BRAKE = 8'h10;
  localparam logic [7:0] OFS_MOTION = 8'h14;
  localparam logic [7:0] OFS_GPOUT = 8'h18;
  localparam logic [7:0] OFS_CLEAR = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_ENABLE = 8'h24;
  localparam logic [7:0] OFS_MODE = 8'h28;
  // alarm output usage codes
  localparam logic [1:0] CODE_CLOSE = 2'h1;
  localparam logic [1:0] CODE_OPEN = 2'h2;
  localparam logic [1:0] CODE_FREE = 2'h3;
  // i/o point numbering, points are written 1..4
  localparam int NUM_POINTS = 4;
  localparam logic [2:0] POINT_MIN = 3'h1;
  localparam logic [2:0] POINT_MAX = 3'h4;
  // field positions
  localparam int ALARM_PT_LSB = 2;
  localparam int STATUS_EN_BIT = 16;
  localparam int STATUS_FAULT_BIT = 17;
  localparam int SCALE_DIFF_BIT = 2;
  // value limits
  localparam logic [31:0] GAIN_MAX = 32'h0000_7fff;
  localparam logic [31:0] SCALE_MAX = 32'h0000_0007;
  localparam logic [31:0] MODE_MAX = 32'h0000_001f;
  localparam logic [31:0] DIR_MAX = 32'h0000_000f;
  localparam logic [4:0] MODE_ANALOG_POS = 5'h16;
  // reset values
  localparam logic [1:0] RST_CODE = 2'h1;
  localparam logic [1:0] RST_POINT = 2'h0;
  localparam logic [3:0] RST_DIR = 4'h1;
  localparam logic [14:0] RST_GAIN = 15'h0000;
  localparam logic [2:0] RST_SCALE = 3'h0;
  localparam logic [4:0] RST_MODE = 5'h00;

  typedef enum logic [3:0] {
    SEL_ALARM, SEL_GAIN, SEL_SCALE, SEL_DIR, SEL_BRAKE, SEL_MOTION,
    SEL_GPOUT, SEL_CLEAR, SEL_STATUS, SEL_ENABLE, SEL_MODE, SEL_NONE
  } reg_sel_t;

  typedef enum logic [2:0] {OWN_GP, OWN_ALARM, OWN_BRAKE, OWN_MOTION, OWN_TACH} owner_t;
  typedef owner_t [NUM_POINTS-1:0] owner_vec_t;

  // levels offered by each output function, 1 = energized
  typedef struct packed {
    logic alarm;
    logic brake;
    logic motion;
    logic tach;
    logic [NUM_POINTS-1:0] gp;
  } func_drive_t;

  typedef struct packed {
    logic [1:0] alarm_code;
    logic [1:0] alarm_point;
    logic [14:0] pos_gain;
    logic [2:0] scale;
    logic [4:0] cmd_mode;
    logic [NUM_POINTS-1:0] io_dir;
    logic [NUM_POINTS-1:0] gp_level;
    owner_vec_t owner;
    logic [15:0] alarm_bits;
    logic motor_en;
    logic [31:0] prdata;
    logic slverr;
    logic [NUM_POINTS-1:0] pins;
  } state_t;
endpackage

/* hw/drive_alarm_output_config.sv */
// alarm output, output ownership and analog input configuration, apb slave
// assumes a synchronous apb master on pclk; fault conditions arrive as levels
`timescale 1ns/1ps
module drive_alarm_output_config #(
  parameter logic [15:0] drive_fault_mask = 16'hffff
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] fault_cond,
  input wire logic brake_level,
  input wire logic motion_level,
  input wire logic tach_level,
  output logic [alarm_cfg_pkg::NUM_POINTS-1:0] out_energize,
  output logic motor_enabled,
  output logic drive_fault,
  output logic [14:0] position_gain,
  output logic analog_position_mode,
  output logic [2:0] analog_scaling,
  output logic analog_differential
);
  alarm_cfg_pkg::state_t st;
  alarm_cfg_pkg::state_t next_st;
  alarm_cfg_pkg::func_drive_t drive;
  alarm_cfg_pkg::reg_sel_t sel;
  logic [alarm_cfg_pkg::NUM_POINTS-1:0] energize;
  logic wr_fire;
  logic [1:0] wr_code;
  logic [2:0] wr_pt3;
  logic [1:0] wr_pt;
  logic [1:0] wr_bpt;

  // address decode, used for read setup and write commit
  function automatic alarm_cfg_pkg::reg_sel_t decode(input logic [7:0] a);
    unique case (a)
      alarm_cfg_pkg::OFS_ALARM: decode = alarm_cfg_pkg::SEL_ALARM;
      alarm_cfg_pkg::OFS_GAIN: decode = alarm_cfg_pkg::SEL_GAIN;
      alarm_cfg_pkg::OFS_SCALE: decode = alarm_cfg_pkg::SEL_SCALE;
      alarm_cfg_pkg::OFS_DIR: decode = alarm_cfg_pkg::SEL_DIR;
      alarm_cfg_pkg::OFS_BRAKE: decode = alarm_cfg_pkg::SEL_BRAKE;
      alarm_cfg_pkg::OFS_MOTION: decode = alarm_cfg_pkg::SEL_MOTION;
      alarm_cfg_pkg::OFS_GPOUT: decode = alarm_cfg_pkg::SEL_GPOUT;
      alarm_cfg_pkg::OFS_CLEAR: decode = alarm_cfg_pkg::SEL_CLEAR;
      alarm_cfg_pkg::OFS_STATUS: decode = alarm_cfg_pkg::SEL_STATUS;
      alarm_cfg_pkg::OFS_ENABLE: decode = alarm_cfg_pkg::SEL_ENABLE;
      alarm_cfg_pkg::OFS_MODE: decode = alarm_cfg_pkg::SEL_MODE;
      default: decode = alarm_cfg_pkg::SEL_NONE;
    endcase
  endfunction

  // point field 1..4 that is configured as output
  function automatic logic point_ok(input logic [2:0] p, input logic [3:0] dir);
    logic [1:0] idx;
    idx = 2'(p - alarm_cfg_pkg::POINT_MIN);
    point_ok = (p >= alarm_cfg_pkg::POINT_MIN) && (p <= alarm_cfg_pkg::POINT_MAX) && dir[idx];
  endfunction

  // range check of a write value
  function automatic logic value_ok(input alarm_cfg_pkg::reg_sel_t s, input logic [31:0] d,
                                    input logic [3:0] dir);
    unique case (s)
      alarm_cfg_pkg::SEL_ALARM: value_ok = (d[1:0] != 2'h0) && (d[31:5] == 27'h0) &&
        ((d[1:0] == alarm_cfg_pkg::CODE_FREE) || point_ok(d[4:2], dir));
      alarm_cfg_pkg::SEL_GAIN: value_ok = d <= alarm_cfg_pkg::GAIN_MAX;
      alarm_cfg_pkg::SEL_SCALE: value_ok = d <= alarm_cfg_pkg::SCALE_MAX;
      alarm_cfg_pkg::SEL_MODE: value_ok = d <= alarm_cfg_pkg::MODE_MAX;
      alarm_cfg_pkg::SEL_DIR: value_ok = d <= alarm_cfg_pkg::DIR_MAX;
      alarm_cfg_pkg::SEL_GPOUT: value_ok = d <= alarm_cfg_pkg::DIR_MAX;
      alarm_cfg_pkg::SEL_BRAKE: value_ok = (d[31:3] == 29'h0) && point_ok(d[2:0], dir);
      alarm_cfg_pkg::SEL_MOTION: value_ok = (d[31:3] == 29'h0) && point_ok(d[2:0], dir);
      alarm_cfg_pkg::SEL_STATUS: value_ok = 1'b0;
      alarm_cfg_pkg::SEL_NONE: value_ok = 1'b0;
      default: value_ok = 1'b1;
    endcase
  endfunction

  assign sel = decode(paddr);
  // zero wait state; error decided in the setup cycle
  assign pready = 1'b1;
  assign wr_fire = psel && penable && pwrite && !st.slverr;
  assign wr_code = pwdata[1:0];
  assign wr_pt3 = pwdata[4:2];
  assign wr_pt = 2'(wr_pt3 - alarm_cfg_pkg::POINT_MIN);
  assign wr_bpt = 2'(pwdata[2:0] - alarm_cfg_pkg::POINT_MIN);

  // fault status drives the alarm output
  assign drive_fault = |(st.alarm_bits & drive_fault_mask);
  // close on fault for code 1, open on fault for code 2
  assign drive.alarm = (st.alarm_code == alarm_cfg_pkg::CODE_CLOSE) ? drive_fault : !drive_fault;
  assign drive.brake = brake_level;
  assign drive.motion = motion_level;
  assign drive.tach = tach_level;
  assign drive.gp = st.gp_level;

  output_owner_mux u_mux (
    .owner(st.owner),
    .drive(drive),
    .energize(energize)
  );

  // next state of all registers
  always_comb begin
    next_st = st;
    // pins carry energize, energized means logic high
    next_st.pins = energize;
    // set wins, clear keeps persisting causes
    next_st.alarm_bits = st.alarm_bits | fault_cond;
    if (psel && !penable) begin
      next_st.slverr = (sel == alarm_cfg_pkg::SEL_NONE) ||
        (pwrite && !value_ok(sel, pwdata, st.io_dir));
      unique case (sel)
        alarm_cfg_pkg::SEL_ALARM:
          next_st.prdata = 32'({3'(st.alarm_point) + alarm_cfg_pkg::POINT_MIN, st.alarm_code});
        alarm_cfg_pkg::SEL_GAIN: next_st.prdata = 32'(st.pos_gain);
        alarm_cfg_pkg::SEL_SCALE: next_st.prdata = 32'(st.scale);
        alarm_cfg_pkg::SEL_DIR: next_st.prdata = 32'(st.io_dir);
        alarm_cfg_pkg::SEL_GPOUT: next_st.prdata = 32'(st.gp_level);
        alarm_cfg_pkg::SEL_MODE: next_st.prdata = 32'(st.cmd_mode);
        alarm_cfg_pkg::SEL_ENABLE: next_st.prdata = 32'(st.motor_en);
        alarm_cfg_pkg::SEL_STATUS: begin
          next_st.prdata = 32'(st.alarm_bits);
          next_st.prdata[alarm_cfg_pkg::STATUS_EN_BIT] = st.motor_en;
          next_st.prdata[alarm_cfg_pkg::STATUS_FAULT_BIT] = drive_fault;
        end
        default: next_st.prdata = 32'h0000_0000;
      endcase
    end
    if (wr_fire) begin
      unique case (sel)
        alarm_cfg_pkg::SEL_ALARM: begin
          if (wr_code == alarm_cfg_pkg::CODE_FREE) begin
            // code 3 hands the point back to general use
            if (st.owner[st.alarm_point] == alarm_cfg_pkg::OWN_ALARM) begin
              next_st.owner[st.alarm_point] = alarm_cfg_pkg::OWN_GP;
            end
          end else begin
            // take over the point, drop any older alarm point
            for (int i = 0; i < alarm_cfg_pkg::NUM_POINTS; i++) begin
              if (st.owner[i] == alarm_cfg_pkg::OWN_ALARM) begin
                next_st.owner[i] = alarm_cfg_pkg::OWN_GP;
              end
            end
            next_st.owner[wr_pt] = alarm_cfg_pkg::OWN_ALARM;
            next_st.alarm_point = wr_pt;
          end
          next_st.alarm_code = wr_code;
        end
        alarm_cfg_pkg::SEL_BRAKE, alarm_cfg_pkg::SEL_MOTION: begin
          for (int i = 0; i < alarm_cfg_pkg::NUM_POINTS; i++) begin
            if (st.owner[i] == ((sel == alarm_cfg_pkg::SEL_BRAKE) ? alarm_cfg_pkg::OWN_BRAKE :
                alarm_cfg_pkg::OWN_MOTION)) begin
              next_st.owner[i] = alarm_cfg_pkg::OWN_GP;
            end
          end
          // alarm loses its point, code becomes 3
          if (st.owner[wr_bpt] == alarm_cfg_pkg::OWN_ALARM) begin
            next_st.alarm_code = alarm_cfg_pkg::CODE_FREE;
          end
          // new function replaces the old owner
          next_st.owner[wr_bpt] = (sel == alarm_cfg_pkg::SEL_BRAKE) ? alarm_cfg_pkg::OWN_BRAKE :
            alarm_cfg_pkg::OWN_MOTION;
        end
        alarm_cfg_pkg::SEL_GAIN: next_st.pos_gain = pwdata[14:0];
        alarm_cfg_pkg::SEL_SCALE: next_st.scale = pwdata[2:0];
        alarm_cfg_pkg::SEL_MODE: next_st.cmd_mode = pwdata[4:0];
        // direction must be output before alarm use
        alarm_cfg_pkg::SEL_DIR: next_st.io_dir = pwdata[3:0];
        alarm_cfg_pkg::SEL_GPOUT: next_st.gp_level = pwdata[3:0];
        // clear never touches the motor enable
        // clear applied on the access edge itself
        alarm_cfg_pkg::SEL_CLEAR: next_st.alarm_bits = fault_cond;
        alarm_cfg_pkg::SEL_ENABLE: next_st.motor_en = pwdata[0];
        default: next_st.motor_en = st.motor_en;
      endcase
    end
    // any drive fault forces the stage off
    if (|(next_st.alarm_bits & drive_fault_mask)) begin
      next_st.motor_en = 1'b0;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.alarm_code <= alarm_cfg_pkg::RST_CODE;
      st.alarm_point <= alarm_cfg_pkg::RST_POINT;
      st.pos_gain <= alarm_cfg_pkg::RST_GAIN;
      st.scale <= alarm_cfg_pkg::RST_SCALE;
      st.cmd_mode <= alarm_cfg_pkg::RST_MODE;
      st.io_dir <= alarm_cfg_pkg::RST_DIR;
      st.owner <= '{alarm_cfg_pkg::OWN_GP, alarm_cfg_pkg::OWN_GP, alarm_cfg_pkg::OWN_GP,
                    alarm_cfg_pkg::OWN_ALARM};
    end else begin
      st <= next_st;
    end
  end

  // outputs from the state register
  assign prdata = st.prdata;
  assign pslverr = st.slverr;
  assign out_energize = st.pins;
  assign motor_enabled = st.motor_en;
  // gain meaningful in analog position mode
  assign position_gain = st.pos_gain;
  assign analog_position_mode = (st.cmd_mode == alarm_cfg_pkg::MODE_ANALOG_POS);
  assign analog_scaling = st.scale;
  assign analog_differential = st.scale[alarm_cfg_pkg::SCALE_DIFF_BIT];

  // helper for the checks below
  logic [2:0] alarm_owners;
  logic setup_c;
  always_comb begin
    alarm_owners = 3'h0;
    for (int i = 0; i < alarm_cfg_pkg::NUM_POINTS; i++) begin
      alarm_owners = alarm_owners + 3'(st.owner[i] == alarm_cfg_pkg::OWN_ALARM);
    end
  end
  // setup cycle of an apb transfer
  assign setup_c = psel && !penable;

  // all checks run on pclk and rest while in reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // alarm pin follows the drive fault in code 1 and inverts it in code 2
  alarm_close_a: assert property (
    st.alarm_code == alarm_cfg_pkg::CODE_CLOSE && st.owner[st.alarm_point] == alarm_cfg_pkg::OWN_ALARM
    |=> out_energize[$past(st.alarm_point)] == $past(drive_fault))
    else $error("alarm code 1 output does not follow fault");
  alarm_open_a: assert property (
    st.alarm_code == alarm_cfg_pkg::CODE_OPEN && st.owner[st.alarm_point] == alarm_cfg_pkg::OWN_ALARM
    |=> out_energize[$past(st.alarm_point)] != $past(drive_fault))
    else $error("alarm code 2 output does not invert fault");

  // ownership and point selection
  one_owner_a: assert property (alarm_owners <= 3'h1)
    else $error("alarm owns more than one point");
  point_range_a: assert property (
    setup_c && pwrite && sel == alarm_cfg_pkg::SEL_ALARM && wr_code != alarm_cfg_pkg::CODE_FREE
    && (wr_pt3 < alarm_cfg_pkg::POINT_MIN || wr_pt3 > alarm_cfg_pkg::POINT_MAX)
    ##1 penable |=> $stable(st.alarm_point) && pslverr)
    else $error("alarm point outside 1 to 4 accepted");
  takeover_a: assert property (
    wr_fire && sel == alarm_cfg_pkg::SEL_ALARM && wr_code != alarm_cfg_pkg::CODE_FREE
    |=> st.owner[$past(wr_pt)] == alarm_cfg_pkg::OWN_ALARM)
    else $error("alarm code did not take over point");
  steal_free_a: assert property (
    wr_fire && (sel == alarm_cfg_pkg::SEL_BRAKE || sel == alarm_cfg_pkg::SEL_MOTION)
    && st.owner[wr_bpt] == alarm_cfg_pkg::OWN_ALARM |=> st.alarm_code == alarm_cfg_pkg::CODE_FREE)
    else $error("alarm code not set to 3 on takeover");
  brake_own_a: assert property (
    wr_fire && sel == alarm_cfg_pkg::SEL_BRAKE |=> st.owner[$past(wr_bpt)] == alarm_cfg_pkg::OWN_BRAKE)
    else $error("brake did not take its point");
  motion_own_a: assert property (
    wr_fire && sel == alarm_cfg_pkg::SEL_MOTION |=> st.owner[$past(wr_bpt)] == alarm_cfg_pkg::OWN_MOTION)
    else $error("motion did not take its point");
  code_free_a: assert property (
    wr_fire && sel == alarm_cfg_pkg::SEL_ALARM && wr_code == alarm_cfg_pkg::CODE_FREE
    |=> st.alarm_code == alarm_cfg_pkg::CODE_FREE && st.owner[st.alarm_point] != alarm_cfg_pkg::OWN_ALARM)
    else $error("code 3 left the alarm on its point");
  dir_first_a: assert property (
    setup_c && pwrite && sel == alarm_cfg_pkg::SEL_ALARM && wr_code != alarm_cfg_pkg::CODE_FREE
    && wr_pt3 >= alarm_cfg_pkg::POINT_MIN && wr_pt3 <= alarm_cfg_pkg::POINT_MAX && !st.io_dir[wr_pt]
    |=> pslverr)
    else $error("alarm point accepted while not an output");

  // clear behaviour
  clear_keep_a: assert property (
    wr_fire && sel == alarm_cfg_pkg::SEL_CLEAR |=> st.alarm_bits == $past(fault_cond))
    else $error("clear lost a persisting alarm");
  no_reenable_a: assert property (
    wr_fire && sel == alarm_cfg_pkg::SEL_CLEAR && !motor_enabled |=> !motor_enabled)
    else $error("clear re-enabled the motor");
  clear_read_a: assert property (
    setup_c && !pwrite && sel == alarm_cfg_pkg::SEL_CLEAR |=> prdata == 32'h0000_0000)
    else $error("clear register read nonzero");
  clear_ok_a: assert property (setup_c && sel == alarm_cfg_pkg::SEL_CLEAR |=> !pslverr)
    else $error("clear command refused");
  enable_on_a: assert property (
    wr_fire && sel == alarm_cfg_pkg::SEL_ENABLE && pwdata[0] && !drive_fault
    && !(|(fault_cond & drive_fault_mask)) |=> motor_enabled)
    else $error("enable command did not enable the stage");
  mode_sel_a: assert property (
    wr_fire && sel == alarm_cfg_pkg::SEL_MODE && pwdata[4:0] == alarm_cfg_pkg::MODE_ANALOG_POS
    |=> analog_position_mode)
    else $error("analog position mode not entered");
  fault_off_a: assert property (drive_fault |-> !motor_enabled)
    else $error("motor enabled during drive fault");

  // rejected writes leave settings alone
  reject_code_a: assert property (
    setup_c && pwrite && sel == alarm_cfg_pkg::SEL_ALARM && wr_code == 2'h0
    |=> pslverr ##1 $stable(st.alarm_code))
    else $error("alarm code 0 not rejected");
  scale_keep_a: assert property (
    setup_c && pwrite && sel == alarm_cfg_pkg::SEL_SCALE && pwdata > alarm_cfg_pkg::SCALE_MAX
    ##1 penable |=> $stable(analog_scaling))
    else $error("bad scaling code stored");
  gain_keep_a: assert property (
    setup_c && pwrite && sel == alarm_cfg_pkg::SEL_GAIN && pwdata > alarm_cfg_pkg::GAIN_MAX
    ##1 penable |=> $stable(position_gain) && pslverr)
    else $error("gain above limit stored");
  diff_code_a: assert property (
    wr_fire && sel == alarm_cfg_pkg::SEL_SCALE |=> analog_differential == ($past(pwdata) >= 32'h0000_0004))
    else $error("input group does not follow scaling code");
  none_err_a: assert property (setup_c && sel == alarm_cfg_pkg::SEL_NONE |=> pslverr)
    else $error("unmapped address not refused");

  // main scenarios
  alarm_take_c: cover property (wr_fire && sel == alarm_cfg_pkg::SEL_ALARM ##1 drive_fault);
  brake_steal_c: cover property (wr_fire && sel == alarm_cfg_pkg::SEL_BRAKE
    && st.owner[wr_bpt] == alarm_cfg_pkg::OWN_ALARM);
  clear_held_c: cover property (wr_fire && sel == alarm_cfg_pkg::SEL_CLEAR && |fault_cond);
  code_free_c: cover property (wr_fire && sel == alarm_cfg_pkg::SEL_ALARM && wr_code == alarm_cfg_pkg::CODE_FREE);
  motion_steal_c: cover property (wr_fire && sel == alarm_cfg_pkg::SEL_MOTION
    && st.owner[wr_bpt] == alarm_cfg_pkg::OWN_ALARM);
endmodule

/* hw/output_owner_mux.sv */
// per-point output selection by the function that owns the point
// assumes owners come from registered state of the configuration block
`timescale 1ns/1ps
module output_owner_mux (
  input wire alarm_cfg_pkg::owner_vec_t owner,
  input wire alarm_cfg_pkg::func_drive_t drive,
  output logic [alarm_cfg_pkg::NUM_POINTS-1:0] energize
);
  genvar i;
  generate
    for (i = 0; i < alarm_cfg_pkg::NUM_POINTS; i++) begin : g_point
      always_comb begin
        unique case (owner[i])
          alarm_cfg_pkg::OWN_ALARM: energize[i] = drive.alarm;
          alarm_cfg_pkg::OWN_BRAKE: energize[i] = drive.brake;
          alarm_cfg_pkg::OWN_MOTION: energize[i] = drive.motion;
          alarm_cfg_pkg::OWN_TACH: energize[i] = drive.tach;
          alarm_cfg_pkg::OWN_GP: energize[i] = drive.gp[i];
          default: energize[i] = 1'b0;
        endcase
      end
    end
  endgenerate
endmodule

/* verif/drive_alarm_output_config_tb_top.sv */
// self-checking bench for the alarm output and analog configuration block
// assumes the host model drives apb; fault and function levels come from here
`timescale 1ns/1ps
module drive_alarm_output_config_tb_top;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} note_t;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] fault_cond;
  logic brake_level, motion_level, tach_level;
  logic [3:0] out_energize;
  logic motor_enabled, drive_fault, analog_position_mode, analog_differential;
  logic [14:0] position_gain;
  logic [2:0] analog_scaling;
  note_t notes[$];
  note_t nt;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  int g;

  // 250 mhz clock
  always #2 pclk = ~pclk;

  host_apb_model HOST (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready);

  drive_alarm_output_config DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .fault_cond, .brake_level, .motion_level, .tach_level, .out_energize, .motor_enabled, .drive_fault,
    .position_gain, .analog_position_mode, .analog_scaling, .analog_differential);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // writes note only the error flag, reads note data as well
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    notes.push_back('{32'h0, 32'h0, e});
    HOST.xfer(1'h1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic e);
    notes.push_back('{x, 32'hffffffff, e});
    HOST.xfer(1'h0, a, 32'h0);
  endtask

  // outputs lag a committed write or a fault by up to two edges
  task automatic settle;
    repeat (3) @(posedge pclk);
    #1;
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // completed transfers are matched against the oldest note
  always @(posedge pclk) begin
    if (psel === 1'h1 && penable === 1'h1 && pready === 1'h1) begin
      if (notes.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        nt = notes.pop_front();
        chk(prdata & nt.m, nt.d);
        chk(32'(pslverr), 32'(nt.e));
      end
    end
  end

  // hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end

  initial begin
    void'($urandom(32'h49ff51be));
    fault_cond = 16'h0;
    brake_level = 1'h0;
    motion_level = 1'h0;
    tach_level = 1'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    rd(alarm_cfg_pkg::OFS_ALARM, 32'h5, 1'h0);
    rd(alarm_cfg_pkg::OFS_STATUS, 32'h0, 1'h0);
    rd(8'h2c, 32'h0, 1'h1);
    wr(alarm_cfg_pkg::OFS_STATUS, 32'h0, 1'h1);
    // scaling codes, both input groups
    for (int i = 0; i < 8; i++) begin
      wr(alarm_cfg_pkg::OFS_SCALE, 32'(i), 1'h0);
      rd(alarm_cfg_pkg::OFS_SCALE, 32'(i), 1'h0);
      settle();
      chk(32'(analog_scaling), 32'(i));
      chk(32'(analog_differential), 32'(i >= 4));
    end
    wr(alarm_cfg_pkg::OFS_SCALE, 32'h8, 1'h1);
    rd(alarm_cfg_pkg::OFS_SCALE, 32'h7, 1'h0);
    // gain limits and analog position mode
    wr(alarm_cfg_pkg::OFS_GAIN, 32'h7fff, 1'h0);
    rd(alarm_cfg_pkg::OFS_GAIN, 32'h7fff, 1'h0);
    wr(alarm_cfg_pkg::OFS_GAIN, 32'h8000, 1'h1);
    g = $urandom % 32768;
    wr(alarm_cfg_pkg::OFS_GAIN, 32'(g), 1'h0);
    wr(alarm_cfg_pkg::OFS_MODE, 32'h16, 1'h0);
    settle();
    chk(32'(position_gain), 32'(g));
    chk(32'(analog_position_mode), 32'h1);
    wr(alarm_cfg_pkg::OFS_MODE, 32'h15, 1'h0);
    settle();
    chk(32'(analog_position_mode), 32'h0);
    // points made outputs before alarm assignment
    wr(alarm_cfg_pkg::OFS_ALARM, 32'h9, 1'h1);
    wr(alarm_cfg_pkg::OFS_DIR, 32'h10, 1'h1);
    wr(alarm_cfg_pkg::OFS_BRAKE, 32'h5, 1'h1);
    wr(alarm_cfg_pkg::OFS_DIR, 32'hf, 1'h0);
    wr(alarm_cfg_pkg::OFS_GPOUT, 32'h0, 1'h0);
    wr(alarm_cfg_pkg::OFS_ENABLE, 32'h1, 1'h0);
    wr(alarm_cfg_pkg::OFS_ALARM, 32'h9, 1'h0);
    wr(alarm_cfg_pkg::OFS_ALARM, 32'h0, 1'h1);
    wr(alarm_cfg_pkg::OFS_ALARM, 32'h15, 1'h1);
    rd(alarm_cfg_pkg::OFS_ALARM, 32'h9, 1'h0);
    settle();
    chk(32'(motor_enabled), 32'h1);
    @(posedge pclk);
    fault_cond <= 16'h0004;
    settle();
    chk(32'(out_energize), 32'h2);
    chk(32'(drive_fault), 32'h1);
    chk(32'(motor_enabled), 32'h0);
    wr(alarm_cfg_pkg::OFS_ALARM, 32'ha, 1'h0);
    wr(alarm_cfg_pkg::OFS_ENABLE, 32'h1, 1'h0);
    settle();
    chk(32'(out_energize), 32'h0);
    chk(32'(motor_enabled), 32'h0);
    // clearing while the cause persists, then after it is gone
    wr(alarm_cfg_pkg::OFS_CLEAR, 32'h0, 1'h0);
    rd(alarm_cfg_pkg::OFS_STATUS, 32'h20004, 1'h0);
    @(posedge pclk);
    fault_cond <= 16'h0;
    rd(alarm_cfg_pkg::OFS_STATUS, 32'h20004, 1'h0);
    wr(alarm_cfg_pkg::OFS_CLEAR, 32'h0, 1'h0);
    rd(alarm_cfg_pkg::OFS_STATUS, 32'h0, 1'h0);
    rd(alarm_cfg_pkg::OFS_CLEAR, 32'h0, 1'h0);
    settle();
    chk(32'(out_energize), 32'h2);
    wr(alarm_cfg_pkg::OFS_ENABLE, 32'h1, 1'h0);
    rd(alarm_cfg_pkg::OFS_STATUS, 32'h10000, 1'h0);
    // alarm takes over a general purpose point
    wr(alarm_cfg_pkg::OFS_GPOUT, 32'h8, 1'h0);
    wr(alarm_cfg_pkg::OFS_ALARM, 32'h11, 1'h0);
    settle();
    chk(32'(out_energize), 32'h0);
    // brake then motion take points, alarm steps back
    @(posedge pclk);
    brake_level <= 1'h1;
    motion_level <= 1'h1;
    wr(alarm_cfg_pkg::OFS_BRAKE, 32'h4, 1'h0);
    rd(alarm_cfg_pkg::OFS_ALARM, 32'h13, 1'h0);
    wr(alarm_cfg_pkg::OFS_MOTION, 32'h1, 1'h0);
    settle();
    chk(32'(out_energize), 32'h9);
    // motion takes the alarm point, then codes 2 and 3 on point 2
    wr(alarm_cfg_pkg::OFS_ALARM, 32'hd, 1'h0);
    wr(alarm_cfg_pkg::OFS_MOTION, 32'h3, 1'h0);
    rd(alarm_cfg_pkg::OFS_ALARM, 32'hf, 1'h0);
    settle();
    chk(32'(out_energize), 32'hc);
    wr(alarm_cfg_pkg::OFS_ALARM, 32'ha, 1'h0);
    settle();
    chk(32'(out_energize), 32'he);
    wr(alarm_cfg_pkg::OFS_ALARM, 32'h3, 1'h0);
    rd(alarm_cfg_pkg::OFS_ALARM, 32'hb, 1'h0);
    settle();
    chk(32'(out_energize), 32'hc);
    // reset in mid-run restores the power-up setup
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    rd(alarm_cfg_pkg::OFS_ALARM, 32'h5, 1'h0);
    rd(alarm_cfg_pkg::OFS_DIR, 32'h1, 1'h0);
    settle();
    chk(32'(out_energize), 32'h0);
    chk(32'(motor_enabled), 32'h0);
    repeat (2) @(posedge pclk);
    chk(32'(notes.size()), 32'h0);
    results();
  end
endmodule

/* verif/host_apb_model.sv */
// apb master standing in for the host controller that sends configuration commands
// assumes pclk runs free and the slave raises pready at some access edge
`timescale 1ns/1ps
module host_apb_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready
);
  // idle bus at time zero
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // one transfer: setup cycle, then access held until pready is seen high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    psel <= 1'h0;
    penable <= 1'h0;
    // released lines carry no stale value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
